// ---- ecf_pkg.sv ----
package ecf_pkg;
  localparam int POS_W = 32;
  localparam int RAM_DEPTH = 32;
  localparam int RAM_AW = 5;
  localparam int TBL_PTS = 16;
  localparam logic [RAM_AW-1:0] LAST_PT = 5'h0F;
  localparam int CW_EN = 4;
  localparam int CW_SPD = 5;
  localparam int CW_ABS = 6;
  localparam int CW_HALT = 8;
  localparam int SW_TGT = 10;
  localparam int SW_FERR = 13;
  localparam logic [15:0] CW_RESET = 16'h0000;
  localparam logic [15:0] REF_ONLINE = 16'h0001;
  localparam logic [15:0] REF_ANALOG = 16'h0002;
  localparam logic [15:0] REF_DIGITAL = 16'h0003;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SLOW_LOOP_NS = 1000000;
  localparam int SLOW_CYC = SLOW_LOOP_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [6:0] other_hi;
    logic halt;
    logic other_b7;
    logic abs_mode;
    logic spd_lim;
    logic enable;
    logic [3:0] other_lo;
  } ecf_ctrl_t;

  typedef struct packed {
    logic [1:0] other_hi;
    logic ferr;
    logic rsv12;
    logic other_b11;
    logic tgt;
    logic [9:0] other_lo;
  } ecf_stat_t;

  typedef struct packed {
    logic [31:0] offset;
    logic [31:0] resolution;
    logic [31:0] prof_vel;
    logic [31:0] prof_acc;
    logic [31:0] ferr_win;
    logic [2:0] step_shift;
  } ecf_cfg_t;

  typedef enum logic [2:0] {
    L_IDLE = 3'b001,
    L_READ = 3'b010,
    L_WAIT = 3'b100
  } ecf_load_t;

  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_WRAP = 4'b0010,
    M_FETCH = 4'b0100,
    M_APPLY = 4'b1000
  } ecf_mot_t;
endpackage : ecf_pkg

// ---- ecf_sync3.sv ----
`timescale 1ns/1ps
module ecf_sync3 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic din_i,
  output logic dout_o
);
  logic s1_r, s2_r, s3_r, out_r, out_nxt;

  // The first stage feeds only the second; the output follows once stages two and three agree.
  always_comb begin
    out_nxt = (s2_r == s3_r) ? s3_r : out_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      out_r <= 1'b0;
    end else begin
      s1_r <= din_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign dout_o = out_r;
endmodule : ecf_sync3

// ---- ecf_follower.sv ----
`timescale 1ns/1ps
module ecf_follower import ecf_pkg::*; #(
  parameter int SLOW_CYCLES = SLOW_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ctrl_wr_i,
  input wire logic [15:0] ctrl_i,
  output logic [15:0] status_o,
  output logic cam_active_o,
  input wire ecf_cfg_t cfg_i,
  input wire logic [15:0] ext_ref_type_i,
  input wire logic digital_quad_i,
  input wire logic [31:0] online_pos_i,
  input wire logic [15:0] analog_i,
  input wire logic pls_a_i,
  input wire logic dir_b_i,
  input wire logic load_wr_i,
  input wire logic [15:0] load_addr_i,
  input wire logic [15:0] run_addr_i,
  output logic nv_rd_o,
  output logic [15:0] nv_addr_o,
  input wire logic [31:0] nv_data_i,
  input wire logic nv_valid_i,
  input wire logic [31:0] actual_pos_i,
  output logic [31:0] demand_pos_o,
  output logic [31:0] master_pos_o,
  output logic copy_busy_o
);
  logic pa_s, db_s;
  ecf_sync3 u_sync_a (.clk_i(clk_i), .rst_i(rst_i), .din_i(pls_a_i), .dout_o(pa_s));
  ecf_sync3 u_sync_b (.clk_i(clk_i), .rst_i(rst_i), .din_i(dir_b_i), .dout_o(db_s));

  // Control word register and slow-loop tick.
  ecf_ctrl_t ctrl_r, ctrl_nxt;
  logic en_d_r, en_d_nxt;
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;

  always_comb begin
    ctrl_nxt = ctrl_wr_i ? ecf_ctrl_t'(ctrl_i) : ctrl_r;
    en_d_nxt = ctrl_r.enable;
    tick_nxt = (tick_cnt_r == 32'(SLOW_CYCLES - 1));
    tick_cnt_nxt = tick_nxt ? 32'h00000000 : tick_cnt_r + 32'h00000001;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= ecf_ctrl_t'(CW_RESET);
      en_d_r <= 1'b0;
      tick_cnt_r <= 32'h00000000;
      tick_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      en_d_r <= en_d_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Master position selection and digital counter.
  logic pa_d_r, db_d_r;
  logic [31:0] dig_cnt_r, dig_cnt_nxt, master_r, master_nxt;

  always_comb begin
    dig_cnt_nxt = dig_cnt_r;
    if (digital_quad_i) begin
      if ((pa_s ^ pa_d_r) ^ (db_s ^ db_d_r)) begin
        dig_cnt_nxt = (pa_s ^ db_d_r) ? dig_cnt_r + 32'h00000001 : dig_cnt_r - 32'h00000001;
      end
    end else if (pa_s && !pa_d_r) begin
      dig_cnt_nxt = db_s ? dig_cnt_r - 32'h00000001 : dig_cnt_r + 32'h00000001;
    end
    // Reserved reference types hold the last master position.
    if (ext_ref_type_i == REF_ONLINE) begin
      master_nxt = online_pos_i;
    end else if (ext_ref_type_i == REF_ANALOG) begin
      master_nxt = {{16{analog_i[15]}}, analog_i};
    end else if (ext_ref_type_i == REF_DIGITAL) begin
      master_nxt = dig_cnt_r;
    end else begin
      master_nxt = master_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_d_r <= 1'b0;
      db_d_r <= 1'b0;
      dig_cnt_r <= 32'h00000000;
      master_r <= 32'h00000000;
    end else begin
      pa_d_r <= pa_s;
      db_d_r <= db_s;
      dig_cnt_r <= dig_cnt_nxt;
      master_r <= master_nxt;
    end
  end

  // Table loader from storage into RAM.
  ecf_load_t ld_r, ld_nxt;
  logic [31:0] ram_r [RAM_DEPTH];
  logic [31:0] ram_nxt [RAM_DEPTH];
  logic [15:0] nv_addr_r, nv_addr_nxt;
  logic [RAM_AW-1:0] dst_r, dst_nxt, cnt_r, cnt_nxt;

  always_comb begin
    ld_nxt = ld_r;
    ram_nxt = ram_r;
    nv_addr_nxt = nv_addr_r;
    dst_nxt = dst_r;
    cnt_nxt = cnt_r;
    case (ld_r)
      L_IDLE: begin
        if (load_wr_i) begin
          nv_addr_nxt = load_addr_i;
          dst_nxt = run_addr_i[RAM_AW-1:0];
          cnt_nxt = 5'h00;
          ld_nxt = L_READ;
        end
      end
      L_READ: begin
        ld_nxt = L_WAIT;
      end
      L_WAIT: begin
        if (nv_valid_i) begin
          ram_nxt[dst_r + cnt_r] = nv_data_i;
          nv_addr_nxt = nv_addr_r + 16'h0001;
          cnt_nxt = cnt_r + 5'h01;
          ld_nxt = (cnt_r == LAST_PT) ? L_IDLE : L_READ;
        end
      end
      default: ld_nxt = L_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ld_r <= L_IDLE;
      nv_addr_r <= 16'h0000;
      dst_r <= 5'h00;
      cnt_r <= 5'h00;
      for (int i = 0; i < RAM_DEPTH; i++) begin
        ram_r[i] <= 32'h00000000;
      end
    end else begin
      ld_r <= ld_nxt;
      nv_addr_r <= nv_addr_nxt;
      dst_r <= dst_nxt;
      cnt_r <= cnt_nxt;
      ram_r <= ram_nxt;
    end
  end

  // Motion: table lookup, interpolation and demand update once per slow-loop tick.
  ecf_mot_t mt_r, mt_nxt;
  logic active_r, active_nxt, first_r, first_nxt, ferr_r, ferr_nxt;
  logic [RAM_AW-1:0] base_r, base_nxt, idx, idx1;
  logic signed [31:0] x_r, x_nxt, xprev_r, xprev_nxt, y_r, y_nxt, yold_r, yold_nxt;
  logic signed [31:0] dem_r, dem_nxt, vel_r, vel_nxt, inc, corr, delta, half, lim, acc, xs;
  logic signed [32:0] span, err;
  logic signed [42:0] prod;
  logic [7:0] frac;
  logic start;

  always_comb begin
    mt_nxt = mt_r;
    active_nxt = active_r;
    first_nxt = first_r;
    base_nxt = base_r;
    x_nxt = x_r;
    xprev_nxt = xprev_r;
    y_nxt = y_r;
    yold_nxt = yold_r;
    dem_nxt = dem_r;
    vel_nxt = vel_r;
    inc = 32'sh00000000;
    corr = 32'sh00000000;
    lim = $signed(cfg_i.prof_vel);
    acc = $signed(cfg_i.prof_acc);
    half = $signed(cfg_i.resolution >> 1);
    delta = x_r - xprev_r;
    // Clamp on the full quotient, so large or negative inputs never alias back into the table.
    xs = x_r >>> cfg_i.step_shift;
    if (xs < 0) begin
      idx = 5'h00;
    end else if (xs > $signed(32'(LAST_PT))) begin
      idx = LAST_PT;
    end else begin
      idx = 5'(xs);
    end
    idx1 = (idx == LAST_PT) ? idx : idx + 5'h01;
    frac = 8'(x_r) & ((8'h01 << cfg_i.step_shift) - 8'h01);
    span = 33'($signed(ram_r[base_r + idx1])) - 33'($signed(ram_r[base_r + idx]));
    prod = span * $signed({1'b0, frac});
    start = ctrl_r.enable && !en_d_r;
    if (start) begin
      active_nxt = 1'b1;
      first_nxt = 1'b1;
      base_nxt = run_addr_i[RAM_AW-1:0];
    end
    case (mt_r)
      M_IDLE: begin
        if (tick_r && active_r) begin
          x_nxt = $signed(master_r - cfg_i.offset);
          mt_nxt = M_WRAP;
        end
      end
      M_WRAP: begin
        // Iterative reduction keeps the modulo cheap; the master moves little per sample.
        if (cfg_i.resolution == 32'h00000000) begin
          mt_nxt = M_FETCH;
        end else if (x_r < 0) begin
          x_nxt = x_r + $signed(cfg_i.resolution);
        end else if (x_r >= $signed(cfg_i.resolution)) begin
          x_nxt = x_r - $signed(cfg_i.resolution);
        end else begin
          mt_nxt = M_FETCH;
        end
      end
      M_FETCH: begin
        y_nxt = $signed(ram_r[base_r + idx]) + 32'(prod >>> cfg_i.step_shift);
        mt_nxt = M_APPLY;
      end
      M_APPLY: begin
        mt_nxt = M_IDLE;
        xprev_nxt = x_r;
        if (!ctrl_r.abs_mode) begin
          if (delta < -half) begin
            corr = $signed(ram_r[base_r + LAST_PT] - ram_r[base_r]);
          end else if (delta > half) begin
            corr = $signed(ram_r[base_r] - ram_r[base_r + LAST_PT]);
          end
          inc = first_r ? 32'sh00000000 : y_r - yold_r + corr;
          yold_nxt = y_r;
        end else begin
          inc = y_r - dem_r;
          if (ctrl_r.spd_lim) begin
            if (inc > lim) begin
              inc = lim;
            end else if (inc < -lim) begin
              inc = -lim;
            end
          end
        end
        if (!start) begin
          first_nxt = 1'b0;
        end
        if (ctrl_r.halt) begin
          if (vel_r > acc) begin
            vel_nxt = vel_r - acc;
          end else if (vel_r < -acc) begin
            vel_nxt = vel_r + acc;
          end else begin
            vel_nxt = 32'sh00000000;
          end
          if (vel_r == 0 && !ctrl_r.enable) begin
            active_nxt = 1'b0;
          end
        end else begin
          vel_nxt = inc;
        end
        dem_nxt = dem_r + vel_nxt;
      end
      default: mt_nxt = M_IDLE;
    endcase
    err = 33'(dem_r) - 33'($signed(actual_pos_i));
    ferr_nxt = (err < 0 ? -err : err) > $signed({1'b0, cfg_i.ferr_win});
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mt_r <= M_IDLE;
      active_r <= 1'b0;
      first_r <= 1'b0;
      ferr_r <= 1'b0;
      base_r <= 5'h00;
      x_r <= 32'sh00000000;
      xprev_r <= 32'sh00000000;
      y_r <= 32'sh00000000;
      yold_r <= 32'sh00000000;
      dem_r <= 32'sh00000000;
      vel_r <= 32'sh00000000;
    end else begin
      mt_r <= mt_nxt;
      active_r <= active_nxt;
      first_r <= first_nxt;
      ferr_r <= ferr_nxt;
      base_r <= base_nxt;
      x_r <= x_nxt;
      xprev_r <= xprev_nxt;
      y_r <= y_nxt;
      yold_r <= yold_nxt;
      dem_r <= dem_nxt;
      vel_r <= vel_nxt;
    end
  end

  ecf_stat_t stat;
  always_comb begin
    stat = '0;
    stat.tgt = ctrl_r.halt && (vel_r == 0);
    stat.ferr = ferr_r;
  end

  assign status_o = stat;
  assign cam_active_o = active_r;
  assign nv_rd_o = (ld_r == L_READ);
  assign nv_addr_o = nv_addr_r;
  assign copy_busy_o = (ld_r != L_IDLE);
  assign demand_pos_o = dem_r;
  assign master_pos_o = master_r;
endmodule : ecf_follower

// ---- ecf_nv_store.sv ----
`timescale 1ns/1ps
module ecf_nv_store (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rd_i,
  input wire logic [15:0] addr_i,
  output logic [31:0] data_o,
  output logic valid_o
);
  logic [2:0] wait_r;
  logic [15:0] addr_r;
  // Odd addresses answer slowly, so the loader sees both prompt and late words.
  always @(posedge clk_i) begin
    valid_o <= 1'b0;
    data_o <= ~data_o;
    if (rst_i) begin
      wait_r <= 3'h0;
      data_o <= 32'h0;
    end else if (rd_i) begin
      addr_r <= addr_i;
      wait_r <= addr_i[0] ? 3'h4 : 3'h1;
    end else if (wait_r == 3'h1) begin
      valid_o <= 1'b1;
      data_o <= {12'h000, addr_r, 4'h0};
      wait_r <= 3'h0;
    end else if (wait_r != 3'h0) begin
      wait_r <= wait_r - 3'h1;
    end
  end
endmodule : ecf_nv_store

// ---- ecf_follower_checker.sv ----
`timescale 1ns/1ps
module ecf_follower_checker import ecf_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ctrl_wr_i,
  input wire logic [15:0] ctrl_i,
  input wire logic [15:0] status_o,
  input wire logic cam_active_o,
  input wire ecf_cfg_t cfg_i,
  input wire logic [15:0] ext_ref_type_i,
  input wire logic [31:0] online_pos_i,
  input wire logic load_wr_i,
  input wire logic [15:0] load_addr_i,
  input wire logic nv_rd_o,
  input wire logic [15:0] nv_addr_o,
  input wire logic [31:0] actual_pos_i,
  input wire logic [31:0] demand_pos_o,
  input wire logic [31:0] master_pos_o,
  input wire logic copy_busy_o
);
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [31:0] dem_r, step, gap, step_mag, gap_mag;
  always_comb begin
    ctrl_nxt = rst_i ? 16'h0000 : (ctrl_wr_i ? ctrl_i : ctrl_r);
    step = demand_pos_o - dem_r;
    gap = demand_pos_o - actual_pos_i;
    step_mag = step[31] ? -step : step;
    gap_mag = gap[31] ? -gap : gap;
  end
  always_ff @(posedge clk_i) begin
    ctrl_r <= ctrl_nxt;
    dem_r <= demand_pos_o;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_start;
    ctrl_wr_i && ctrl_i[CW_EN] && !ctrl_i[CW_HALT] && !ctrl_r[CW_EN];
  endsequence
  sequence s_load;
    load_wr_i && !copy_busy_o;
  endsequence
  a_start_active: assert property (s_start |-> ##2 cam_active_o)
    else $error("camming did not start");
  a_fall_keeps: assert property (cam_active_o && ctrl_wr_i && !ctrl_i[CW_EN] &&
    !ctrl_i[CW_HALT] && !ctrl_r[CW_HALT] |-> ##1 cam_active_o ##1 cam_active_o)
    else $error("camming stopped without halt");
  a_tgt_nohalt: assert property (!ctrl_r[CW_HALT] && !$past(ctrl_r[CW_HALT]) |->
    !status_o[SW_TGT]) else $error("target flag without halt");
  a_status_rsvd: assert property ((status_o & 16'hDBFF) == 16'h0000)
    else $error("unused status bit set");
  a_ferr_flag: assert property (1'b1 |=> status_o[SW_FERR] == $past(gap_mag > cfg_i.ferr_win))
    else $error("following error flag wrong");
  a_load_read: assert property (s_load |=> nv_rd_o && nv_addr_o == $past(load_addr_i))
    else $error("copy did not start");
  a_rd_pulse: assert property (nv_rd_o |=> !nv_rd_o)
    else $error("read strobe too long");
  a_copy_done: assert property (s_load |-> ##[1:200] !copy_busy_o)
    else $error("copy did not finish");
  a_online_src: assert property (ext_ref_type_i == REF_ONLINE |=>
    master_pos_o == $past(online_pos_i)) else $error("online master not taken");
  a_abs_clamp: assert property (cam_active_o && $past(cam_active_o) && ctrl_r[CW_ABS] &&
    ctrl_r[CW_SPD] && !ctrl_r[CW_HALT] |-> step_mag <= cfg_i.prof_vel)
    else $error("speed limit exceeded");
endmodule : ecf_follower_checker
bind ecf_follower ecf_follower_checker u_ecf_follower_checker (.clk_i, .rst_i, .ctrl_wr_i,
  .ctrl_i, .status_o, .cam_active_o, .cfg_i, .ext_ref_type_i, .online_pos_i, .load_wr_i,
  .load_addr_i, .nv_rd_o, .nv_addr_o, .actual_pos_i, .demand_pos_o, .master_pos_o,
  .copy_busy_o);

// ---- electronic_cam_follower_test.sv ----
`timescale 1ns/1ps
module electronic_cam_follower_test import ecf_pkg::*;;
  localparam int SLOW = 20;
  logic clk_i = 1'b0, rst_i = 1'b1, ctrl_wr_i = 1'b0, load_wr_i = 1'b0;
  logic quad = 1'b0, pls = 1'b0, dir = 1'b0, nv_valid, nv_rd, busy, active;
  logic [15:0] ctrl_i = 16'h0000, ref_type = REF_ONLINE, analog = 16'h0000, status, nv_addr;
  // Nonzero addresses show that both the copy and the lookup honour them.
  logic [15:0] load_addr = 16'h0010, run_addr = 16'h0010;
  logic [31:0] online = 32'h0, actual = 32'h0, nv_data, demand, master, d0;
  ecf_cfg_t cfg = '{32'h0, 32'h0, 32'h4, 32'h1000, 32'h8, 3'h2};
  int fail_count = 0, samples_checked = 0, cycles = 0, rd_count = 0;
  ecf_follower #(.SLOW_CYCLES(SLOW)) u_ecf_follower (.clk_i, .rst_i, .ctrl_wr_i, .ctrl_i,
    .status_o(status), .cam_active_o(active), .cfg_i(cfg), .ext_ref_type_i(ref_type),
    .digital_quad_i(quad), .online_pos_i(online), .analog_i(analog), .pls_a_i(pls),
    .dir_b_i(dir), .load_wr_i, .load_addr_i(load_addr), .run_addr_i(run_addr),
    .nv_rd_o(nv_rd), .nv_addr_o(nv_addr), .nv_data_i(nv_data), .nv_valid_i(nv_valid),
    .actual_pos_i(actual), .demand_pos_o(demand), .master_pos_o(master), .copy_busy_o(busy));
  ecf_nv_store u_ecf_nv_store (.clk_i, .rst_i, .rd_i(nv_rd), .addr_i(nv_addr),
    .data_o(nv_data), .valid_o(nv_valid));
  initial forever #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (nv_rd === 1'b1) rd_count++;
    if (cycles == 6000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wait_smp(input int n);
    repeat (n * SLOW) @(posedge clk_i);
    @(negedge clk_i);
  endtask : wait_smp
  task automatic put_ctrl(input logic [15:0] v);
    @(posedge clk_i);
    ctrl_wr_i <= 1'b1;
    ctrl_i <= v;
    @(posedge clk_i);
    ctrl_wr_i <= 1'b0;
  endtask : put_ctrl
  task automatic set_pos(input logic [31:0] p);
    @(posedge clk_i);
    online <= p;
    wait_smp(2);
  endtask : set_pos
  task automatic t_load;
    @(negedge clk_i);
    check({16'h0, status}, 32'h0);
    check(demand, 32'h0);
    @(posedge clk_i);
    load_wr_i <= 1'b1;
    @(posedge clk_i);
    load_wr_i <= 1'b0;
    repeat (200) begin
      @(negedge clk_i);
      if (busy !== 1'b1) break;
    end
    check({31'h0, busy}, 32'h0);
    check(rd_count, 32'h10);
    $display("Test load done");
  endtask : t_load
  task automatic t_abs;
    set_pos(32'h0000000A);
    put_ctrl(16'h0050);
    wait_smp(3);
    check({31'h0, active}, 32'h1);
    check(demand, 32'h128);
    put_ctrl(16'h0000);
    put_ctrl(16'h0070);
    @(posedge clk_i);
    online <= 32'h0000003C;
    wait_smp(2);
    check({31'h0, active}, 32'h1);
    d0 = demand;
    wait_smp(1);
    check(demand, d0 + 32'h4);
    put_ctrl(16'h0170);
    @(negedge clk_i);
    check({16'h0, status & 16'h0400}, 32'h0);
    d0 = demand;
    wait_smp(1);
    check({16'h0, status & 16'h0400}, 32'h400);
    check(demand, d0);
    check({31'h0, active}, 32'h1);
    $display("Test absolute done");
  endtask : t_abs
  task automatic t_rel;
    @(posedge clk_i);
    cfg.resolution <= 32'h40;
    set_pos(32'h0000000A);
    put_ctrl(16'h0000);
    put_ctrl(16'h0030);
    wait_smp(2);
    d0 = demand;
    wait_smp(2);
    check(demand, d0);
    set_pos(32'h0000001E);
    set_pos(32'h0000002C);
    set_pos(32'h00000038);
    check(demand, d0 + 32'hB8);
    set_pos(32'h00000044);
    check(demand, d0 + 32'hD8);
    set_pos(32'h00000038);
    check(demand, d0 + 32'hB8);
    $display("Test relative done");
  endtask : t_rel
  task automatic t_halt;
    check({16'h0, status & 16'h0400}, 32'h0);
    put_ctrl(16'h0100);
    wait_smp(4);
    check({16'h0, status & 16'h0400}, 32'h400);
    check({31'h0, active}, 32'h0);
    put_ctrl(16'h0000);
    wait_smp(1);
    check({16'h0, status & 16'h0400}, 32'h0);
    @(posedge clk_i);
    actual <= demand + 32'h9;
    wait_smp(1);
    check({16'h0, status & 16'h2000}, 32'h2000);
    @(posedge clk_i);
    actual <= demand + 32'h8;
    wait_smp(1);
    check({16'h0, status & 16'h2000}, 32'h0);
    $display("Test halt done");
  endtask : t_halt
  task automatic t_src;
    @(posedge clk_i);
    ref_type <= REF_ANALOG;
    analog <= 16'hFFF0;
    wait_smp(1);
    check(master, 32'hFFFFFFF0);
    @(posedge clk_i);
    ref_type <= REF_DIGITAL;
    dir <= 1'b1;
    wait_smp(1);
    d0 = master;
    repeat (3) begin
      repeat (4) @(posedge clk_i);
      pls <= 1'b1;
      repeat (4) @(posedge clk_i);
      pls <= 1'b0;
    end
    wait_smp(1);
    d0 = master - d0;
    check(d0[31] ? -d0 : d0, 32'h3);
    @(posedge clk_i);
    quad <= 1'b1;
    wait_smp(1);
    d0 = master;
    repeat (4) @(posedge clk_i);
    dir <= 1'b0;
    repeat (4) @(posedge clk_i);
    pls <= 1'b1;
    repeat (4) @(posedge clk_i);
    dir <= 1'b1;
    repeat (4) @(posedge clk_i);
    pls <= 1'b0;
    wait_smp(1);
    d0 = master - d0;
    check(d0[31] ? -d0 : d0, 32'h4);
    $display("Test sources done");
  endtask : t_src
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_load();
    t_abs();
    t_rel();
    t_halt();
    t_src();
    complete_run();
  end
endmodule : electronic_cam_follower_test
